// ==== rtl/rsc_reset_source_controller.sv ====
// Reset source controller: collects supply, pin and clock-loss requests.
// Assumes a single 50 MHz clock; srst acts as the power-on event.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/10ps
module rsc_reset_source_controller #(
   parameter int N_PORTS            = 8,
   parameter int SUPPLY_TIMEOUT_CYC = rsc_pkg::SUPPLY_TIMEOUT_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [3:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   rst_pin_n_i,
   output logic                        rst_pin_o,
   output logic                        rst_pin_oe,
   input  wire logic                   supply_monitor_enable_pin,
   input  wire logic                   supply_low_i,
   input  wire logic                   clock_loss_i,
   input  wire logic                   clk_stable_i,
   output logic                        core_reset_o,
   output logic                        fetch_en_o,
   output logic      [15:0]            fetch_addr_o,
   output logic      [7:0]             stack_ptr_o,
   output logic      [8*N_PORTS-1:0]   port_latch_o,
   output logic                        clk_src_o,
   output logic      [1:0]             osc_setting_o,
   output logic                        wdt_en_o,
   output logic      [2:0]             wdt_interval_o,
   output logic                        irq_o
);

   localparam int CNT_W = $clog2(SUPPLY_TIMEOUT_CYC + 1);

   initial begin
      if (N_PORTS < 1 || SUPPLY_TIMEOUT_CYC < rsc_pkg::PIN_HOLD_CYC) begin
         $error("rsc: unsupported parameter values");
      end
   end

   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   logic [1:0] pin_sync_ff;
   logic [1:0] low_sync_ff;
   logic [1:0] loss_sync_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_sync_ff  <= 2'h3;
         low_sync_ff  <= 2'h0;
         loss_sync_ff <= 2'h0;
      end else begin
         pin_sync_ff  <= {pin_sync_ff[0], rst_pin_n_i};
         low_sync_ff  <= {low_sync_ff[0], supply_low_i};
         loss_sync_ff <= {loss_sync_ff[0], clock_loss_i};
      end
   end

   // ****************************************************************
   // Request decode.
   // ****************************************************************
   rsc_pkg::rsc_state_e state_ff;
   rsc_pkg::rsc_state_e nxt_state;
   rsc_pkg::rsc_cause_e cause_ff;
   rsc_pkg::rsc_cause_e nxt_cause;
   logic [CNT_W-1:0]    cnt_ff;
   logic [CNT_W-1:0]    nxt_cnt;
   logic                monitor_sel_ff;
   logic                loss_en_ff;
   logic [2:0]          drv_hist_ff;
   logic [2:0]          flags_ff;
   logic [2:0]          nxt_flags;

   wire drive_pin = (state_ff == rsc_pkg::ST_HOLD) && (cause_ff == rsc_pkg::CAUSE_POR);
   wire pin_masked = drive_pin | (|drv_hist_ff);
   wire supply_req = low_sync_ff[1] & supply_monitor_enable_pin & monitor_sel_ff;
   wire pin_req = ~pin_sync_ff[1] & ~pin_masked;
   wire loss_req = loss_sync_ff[1] & loss_en_ff;
   wire any_req = supply_req | pin_req | loss_req;
   wire entering = (state_ff != rsc_pkg::ST_HOLD) && any_req;

   wire [CNT_W-1:0] hold_lim = (cause_ff == rsc_pkg::CAUSE_POR) ?
      CNT_W'(SUPPLY_TIMEOUT_CYC - 1) :
      CNT_W'(rsc_pkg::PIN_HOLD_CYC - 1);
   wire hold_done = (state_ff == rsc_pkg::ST_HOLD) && !any_req && (cnt_ff >= hold_lim);

   // ****************************************************************
   // Sequencer.
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_cause = cause_ff;
      nxt_cnt   = cnt_ff;
      nxt_flags = flags_ff;
      if (supply_req) begin
         nxt_state = rsc_pkg::ST_HOLD;
         nxt_cause = rsc_pkg::CAUSE_POR;
         nxt_cnt   = '0;
      end else if (pin_req && !(state_ff == rsc_pkg::ST_HOLD &&
                                cause_ff == rsc_pkg::CAUSE_POR)) begin
         nxt_state = rsc_pkg::ST_HOLD;
         nxt_cause = rsc_pkg::CAUSE_PIN;
         nxt_cnt   = '0;
      end else if (loss_req && state_ff != rsc_pkg::ST_HOLD) begin
         nxt_state = rsc_pkg::ST_HOLD;
         nxt_cause = rsc_pkg::CAUSE_CLK;
         nxt_cnt   = '0;
      end else if (loss_req) begin
         nxt_cnt = '0;
      end else begin
         case (state_ff)
            rsc_pkg::ST_HOLD: begin
               if (hold_done) begin
                  nxt_state = rsc_pkg::ST_WAIT_CLK;
                  nxt_flags = '0;
                  nxt_flags[rsc_pkg::CAUSE_POR_BIT] =
                     (cause_ff == rsc_pkg::CAUSE_POR);
                  nxt_flags[rsc_pkg::CAUSE_PIN_BIT] =
                     (cause_ff == rsc_pkg::CAUSE_PIN);
                  nxt_flags[rsc_pkg::CAUSE_CLK_BIT] =
                     (cause_ff == rsc_pkg::CAUSE_CLK);
               end else begin
                  nxt_cnt = cnt_ff + CNT_W'(1);
               end
            end
            rsc_pkg::ST_WAIT_CLK: begin
               if (clk_stable_i) begin
                  nxt_state = rsc_pkg::ST_RUN;
               end
            end
            rsc_pkg::ST_RUN: begin
               nxt_state = rsc_pkg::ST_RUN;
            end
            default: begin
               nxt_state = rsc_pkg::ST_HOLD;
               nxt_cause = rsc_pkg::CAUSE_POR;
               nxt_cnt   = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff    <= rsc_pkg::ST_HOLD;
         cause_ff    <= rsc_pkg::CAUSE_POR;
         cnt_ff      <= '0;
         flags_ff    <= '0;
         drv_hist_ff <= '0;
      end else begin
         state_ff    <= nxt_state;
         cause_ff    <= nxt_cause;
         cnt_ff      <= nxt_cnt;
         flags_ff    <= nxt_flags;
         drv_hist_ff <= {drv_hist_ff[1:0], drive_pin};
      end
   end

   // ****************************************************************
   // Core-facing and reset pin outputs.
   // ****************************************************************
   logic in_reset_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         in_reset_ff <= 1'b1;
         rst_pin_oe  <= 1'b1;
      end else begin
         in_reset_ff <= (nxt_state == rsc_pkg::ST_HOLD);
         rst_pin_oe  <= (nxt_state == rsc_pkg::ST_HOLD) &&
                        (nxt_cause == rsc_pkg::CAUSE_POR);
      end
   end

   assign rst_pin_o    = 1'b0;
   assign core_reset_o = in_reset_ff;
   assign fetch_en_o   = (state_ff == rsc_pkg::ST_RUN);

   always_ff @(posedge clk) begin
      if (srst || in_reset_ff) begin
         fetch_addr_o   <= rsc_pkg::RESET_VECTOR;
         stack_ptr_o    <= rsc_pkg::STACK_PTR_RST;
         port_latch_o   <= {N_PORTS{rsc_pkg::PORT_LATCH_RST}};
         clk_src_o      <= rsc_pkg::CLK_SRC_INTERNAL;
         osc_setting_o  <= rsc_pkg::OSC_LOWEST;
         wdt_en_o       <= 1'b1;
         wdt_interval_o <= rsc_pkg::WDT_INTERVAL_RST;
      end else begin
         fetch_addr_o   <= fetch_addr_o;
         stack_ptr_o    <= stack_ptr_o;
         port_latch_o   <= port_latch_o;
         clk_src_o      <= clk_src_o;
         osc_setting_o  <= osc_setting_o;
         wdt_en_o       <= wdt_en_o;
         wdt_interval_o <= wdt_interval_o;
      end
   end

   // ****************************************************************
   // Wishbone slave.
   // ****************************************************************
   logic [rsc_pkg::IRQ_W-1:0] irq_st_ff;
   logic [rsc_pkg::IRQ_W-1:0] irq_mk_ff;
   logic [rsc_pkg::IRQ_W-1:0] irq_set;

   wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
   wire wr_cause = wr_lane0 && (wb_adr_i == rsc_pkg::OFS_CAUSE);
   wire wr_irqst = wr_lane0 && (wb_adr_i == rsc_pkg::OFS_IRQ_ST);
   wire wr_irqmk = wr_lane0 && (wb_adr_i == rsc_pkg::OFS_IRQ_MK);

   wire [31:0] status_word = {28'h000_0000, loss_en_ff, monitor_sel_ff,
                              rst_pin_oe, in_reset_ff};
   wire [31:0] rd_data =
      (wb_adr_i == rsc_pkg::OFS_CAUSE)  ? {29'h0000_0000, flags_ff} :
      (wb_adr_i == rsc_pkg::OFS_IRQ_ST) ? {28'h000_0000, irq_st_ff} :
      (wb_adr_i == rsc_pkg::OFS_IRQ_MK) ? {28'h000_0000, irq_mk_ff} :
      (wb_adr_i == rsc_pkg::OFS_STATUS) ? status_word :
      rsc_pkg::DATA_ZERO;

   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= rsc_pkg::DATA_ZERO;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rd_data : rsc_pkg::DATA_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || entering) begin
         monitor_sel_ff <= 1'b1;
         loss_en_ff     <= 1'b0;
      end else if (wr_cause) begin
         monitor_sel_ff <= wb_dat_i[rsc_pkg::CAUSE_POR_BIT];
         loss_en_ff     <= wb_dat_i[rsc_pkg::CAUSE_CLK_BIT];
      end else begin
         monitor_sel_ff <= monitor_sel_ff;
         loss_en_ff     <= loss_en_ff;
      end
   end

   // ****************************************************************
   // Interrupt status and mask.
   // ****************************************************************
   always_comb begin
      irq_set = '0;
      irq_set[rsc_pkg::IRQ_PIN_BIT]    = pin_req && !(state_ff == rsc_pkg::ST_HOLD &&
                                          cause_ff == rsc_pkg::CAUSE_PIN);
      irq_set[rsc_pkg::IRQ_SUPPLY_BIT] = supply_req && !(state_ff == rsc_pkg::ST_HOLD &&
                                          cause_ff == rsc_pkg::CAUSE_POR);
      irq_set[rsc_pkg::IRQ_CLK_BIT]    = loss_req && (state_ff != rsc_pkg::ST_HOLD);
      irq_set[rsc_pkg::IRQ_RUN_BIT]    = (state_ff == rsc_pkg::ST_WAIT_CLK) &&
                                         (nxt_state == rsc_pkg::ST_RUN);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_st_ff <= '0;
         irq_mk_ff <= '0;
      end else begin
         irq_st_ff <= irq_set |
                      (irq_st_ff & ~(wr_irqst ? wb_dat_i[rsc_pkg::IRQ_W-1:0] : '0));
         irq_mk_ff <= wr_irqmk ? wb_dat_i[rsc_pkg::IRQ_W-1:0] : irq_mk_ff;
      end
   end

   assign irq_o = |(irq_st_ff & irq_mk_ff);

endmodule

// ==== rtl/rsc_pkg.sv ====
// Constants, register map and state types of the reset source controller.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
package rsc_pkg;

   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int CLK_HZ             = 50_000_000;
   localparam int SUPPLY_TIMEOUT_MS  = 100;
   localparam int SUPPLY_TIMEOUT_CYC =
      int'((64'(SUPPLY_TIMEOUT_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000);
   localparam int PIN_HOLD_CYC       = 12;

   // ****************************************************************
   // Register offsets and fields.
   // ****************************************************************
   localparam logic [3:0] OFS_CAUSE  = 4'h0;
   localparam logic [3:0] OFS_IRQ_ST = 4'h4;
   localparam logic [3:0] OFS_IRQ_MK = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;

   localparam int CAUSE_PIN_BIT = 0;
   localparam int CAUSE_POR_BIT = 1;
   localparam int CAUSE_CLK_BIT = 2;

   localparam int IRQ_PIN_BIT    = 0;
   localparam int IRQ_SUPPLY_BIT = 1;
   localparam int IRQ_CLK_BIT    = 2;
   localparam int IRQ_RUN_BIT    = 3;
   localparam int IRQ_W          = 4;

   // ****************************************************************
   // Values after reset.
   // ****************************************************************
   localparam logic [15:0] RESET_VECTOR     = 16'h0000;
   localparam logic [7:0]  PORT_LATCH_RST   = 8'hff;
   localparam logic [7:0]  STACK_PTR_RST    = 8'h07;
   localparam logic [2:0]  WDT_INTERVAL_RST = 3'h7;
   localparam logic        CLK_SRC_INTERNAL = 1'h0;
   localparam logic [1:0]  OSC_LOWEST       = 2'h0;
   localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_WAIT_CLK,
      ST_RUN
   } rsc_state_e;

   typedef enum logic [1:0] {
      CAUSE_POR,
      CAUSE_PIN,
      CAUSE_CLK
   } rsc_cause_e;

endpackage

// ==== tb/rsc_checker_asserts.sv ====
// Concurrent checks on the ports of the reset source controller.
// Assumes one clock and a synchronous active-high srst; bound below.
`timescale 1ns/10ps
module rsc_checker #(
   parameter int N_PORTS            = 8,
   parameter int SUPPLY_TIMEOUT_CYC = 50
) (
   input wire logic                 clk,
   input wire logic                 srst,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire logic                 rst_pin_n_i,
   input wire logic                 rst_pin_oe,
   input wire logic                 supply_monitor_enable_pin,
   input wire logic                 supply_low_i,
   input wire logic                 clk_stable_i,
   input wire logic                 core_reset_o,
   input wire logic                 fetch_en_o,
   input wire logic [8*N_PORTS-1:0] port_latch_o,
   input wire logic                 wdt_en_o,
   input wire logic [2:0]           wdt_interval_o
);
   int hold_cnt_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Counts cycles of pin drive with the supply good.
   always_ff @(posedge clk) begin
      if (srst || supply_low_i || !rst_pin_oe) begin
         hold_cnt_ff <= 0;
      end else begin
         hold_cnt_ff <= hold_cnt_ff + 1;
      end
   end
   sequence s_freed;
      $rose(rst_pin_n_i) && core_reset_o && !rst_pin_oe && !$past(rst_pin_oe);
   endsequence
   sequence s_held;
      core_reset_o[*8] ##1 core_reset_o[*5];
   endsequence
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late or long");
   property p_hold; s_freed |-> s_held; endproperty
   a_hold: assert property (p_hold) else $error("pin reset too short");
   property p_enter; (!rst_pin_n_i && !rst_pin_oe)[*8] |-> core_reset_o; endproperty
   a_enter: assert property (p_enter) else $error("pin low ignored");
   property p_latch; core_reset_o[*2] |-> &port_latch_o; endproperty
   a_latch: assert property (p_latch) else $error("port latch not ones");
   property p_exit; $fell(core_reset_o) |-> wdt_en_o && &wdt_interval_o; endproperty
   a_exit: assert property (p_exit) else $error("watchdog not at longest");
   property p_fetch; $rose(fetch_en_o) |-> $past(clk_stable_i) && !core_reset_o; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch before clock stable");
   property p_halt; core_reset_o |-> !fetch_en_o; endproperty
   a_halt: assert property (p_halt) else $error("fetch during reset");
   property p_supply; $fell(rst_pin_oe) |-> hold_cnt_ff >= SUPPLY_TIMEOUT_CYC; endproperty
   a_supply: assert property (p_supply) else $error("pin drive too short");
   property p_mon; (!supply_monitor_enable_pin && !rst_pin_oe)[*4] |=> !rst_pin_oe; endproperty
   a_mon: assert property (p_mon) else $error("trip with monitor off");
endmodule
bind rsc_reset_source_controller rsc_checker #(
   .N_PORTS(N_PORTS), .SUPPLY_TIMEOUT_CYC(SUPPLY_TIMEOUT_CYC)
) u_chk (
   .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .rst_pin_n_i(rst_pin_n_i), .rst_pin_oe(rst_pin_oe), .clk_stable_i(clk_stable_i),
   .supply_monitor_enable_pin(supply_monitor_enable_pin), .supply_low_i(supply_low_i),
   .core_reset_o(core_reset_o), .fetch_en_o(fetch_en_o), .port_latch_o(port_latch_o),
   .wdt_en_o(wdt_en_o), .wdt_interval_o(wdt_interval_o)
);

// ==== tb/rsc_far_side.sv ====
// Far side model: reset pin with pull-up, and the clock source.
// Assumes the bench commands when an outside party pulls the pin.
`timescale 1ns/10ps
module rsc_far_side (
   input  wire logic       clk,
   input  wire logic       pull_low,
   input  wire logic       rst_pin_o,
   input  wire logic       rst_pin_oe,
   input  wire logic       core_reset_o,
   input  wire logic [3:0] stable_dly,
   output logic            rst_pin_n_i,
   output logic            clk_stable_i
);
   logic [3:0] wait_ff;
   // Pull-up on the pin; any party pulling low wins.
   assign rst_pin_n_i  = !(pull_low || (rst_pin_oe && !rst_pin_o));
   // The clock source settles a set time after the core leaves reset.
   assign clk_stable_i = !core_reset_o && wait_ff == stable_dly;
   always_ff @(posedge clk) begin
      wait_ff <= core_reset_o ? 4'h0 : (clk_stable_i ? wait_ff : wait_ff + 4'h1);
   end
endmodule

// ==== tb/rsc_reset_source_controller_tb_top.sv ====
// Testbench of the reset source controller with its far side model.
// Assumes the checker is bound inside the controller.
`timescale 1ns/10ps
module rsc_reset_source_controller_tb_top;
   localparam int TMO = 50;
   logic        clk, srst, cyc, stb, we, mon_en, sup_low, clk_loss, pull_low;
   logic [3:0]  adr, stable_dly;
   logic [31:0] dat_i, dat_o, q;
   logic        ack, pin_n, pin_o, pin_oe, core_rst, fetch_en, clk_src, wdt_en, irq, stable;
   logic [15:0] fetch_addr;
   logic [7:0]  sp;
   logic [63:0] latch;
   logic [2:0]  wdt_iv;
   logic [1:0]  osc;
   int          mismatches, checks, h, s;
   rsc_reset_source_controller #(.SUPPLY_TIMEOUT_CYC(TMO)) dut (
      .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .rst_pin_n_i(pin_n), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
      .supply_monitor_enable_pin(mon_en), .supply_low_i(sup_low), .clock_loss_i(clk_loss),
      .clk_stable_i(stable), .core_reset_o(core_rst), .fetch_en_o(fetch_en),
      .fetch_addr_o(fetch_addr), .stack_ptr_o(sp), .port_latch_o(latch), .clk_src_o(clk_src),
      .osc_setting_o(osc), .wdt_en_o(wdt_en), .wdt_interval_o(wdt_iv), .irq_o(irq));
   rsc_far_side far (.clk(clk), .pull_low(pull_low), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
      .core_reset_o(core_rst), .stable_dly(stable_dly), .rst_pin_n_i(pin_n),
      .clk_stable_i(stable));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat_i <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'h1);
      q = dat_o;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask
   task automatic to_run();
      h = 0;
      s = 0;
      while (core_rst !== 1'h0) begin
         @(posedge clk);
         h++;
      end
      while (fetch_en !== 1'h1) begin
         @(posedge clk);
         s++;
      end
   endtask
   task automatic t_por();
      chk(&latch, 1'h1);
      chk(pin_oe, 1'h1);
      to_run();
      chk(h >= TMO, 1'h1);
      chk({wdt_en, wdt_iv, clk_src, osc}, 7'h78);
      chk({fetch_addr, sp}, 24'h00_0007);
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h2);
      bus(1'h0, 4'hc, 32'h0);
      chk(q, 32'h4);
      bus(1'h0, 4'h2, 32'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_irq();
      bus(1'h1, 4'h8, 32'h8);
      chk(irq, 1'h1);
      bus(1'h1, 4'h4, 32'h8);
      chk(irq, 1'h0);
      bus(1'h1, 4'h8, 32'h4);
   endtask
   task automatic t_pin();
      stable_dly <= 4'h5;
      pull_low <= 1'h1;
      repeat (20) @(posedge clk);
      chk({core_rst, fetch_en, pin_oe}, 3'h4);
      pull_low <= 1'h0;
      to_run();
      chk(h >= 12, 1'h1);
      chk(s >= 5, 1'h1);
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h1);
      bus(1'h0, 4'h4, 32'h0);
      chk({q[30:0], irq}, 32'h0000_0012);
      bus(1'h1, 4'h4, 32'hf);
   endtask
   task automatic t_clk();
      clk_loss <= 1'h1;
      repeat (10) @(posedge clk);
      chk(core_rst, 1'h0);
      clk_loss <= 1'h0;
      repeat (4) @(posedge clk);
      bus(1'h1, 4'h0, 32'h6);
      clk_loss <= 1'h1;
      repeat (10) @(posedge clk);
      chk({core_rst, pin_n}, 2'h3);
      clk_loss <= 1'h0;
      to_run();
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h4);
   endtask
   task automatic t_sup();
      bus(1'h1, 4'h0, 32'h0);
      sup_low <= 1'h1;
      repeat (10) @(posedge clk);
      chk(core_rst, 1'h0);
      sup_low <= 1'h0;
      repeat (4) @(posedge clk);
      bus(1'h1, 4'h0, 32'h2);
      mon_en <= 1'h0;
      sup_low <= 1'h1;
      repeat (10) @(posedge clk);
      chk(core_rst, 1'h0);
      mon_en <= 1'h1;
      repeat (10) @(posedge clk);
      chk({core_rst, pin_oe}, 2'h3);
      sup_low <= 1'h0;
      to_run();
      chk(h >= TMO, 1'h1);
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h2);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   initial begin
      {srst, cyc, stb, we, mon_en, sup_low, clk_loss, pull_low} = 8'h88;
      {adr, stable_dly, dat_i} = 40'h00_0000_0000;
      mismatches = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      t_por();
      t_irq();
      t_pin();
      t_clk();
      t_sup();
      complete_run();
   end
   initial begin
      #200_000;
      mismatches++;
      complete_run();
   end
endmodule
